// ==== common/ppc_map.vh ====
// Register offsets, field limits and reset values of the port pin control group
`ifndef PPC_MAP_VH
`define PPC_MAP_VH

`define PPC_ADDR_W 8
`define PPC_OFS_P4_PULLUP 8'h00
`define PPC_OFS_P7_LEVEL 8'h04
`define PPC_OFS_P8_LEVEL 8'h08
`define PPC_OFS_P9_DATA 8'h0c
`define PPC_OFS_P9_DIR 8'h10
`define PPC_OFS_P9_MODE 8'h14
`define PPC_OFS_P9_OPEN_DRAIN 8'h18
`define PPC_OFS_P9_FUNC 8'h1c
`define PPC_OFS_P9_PULLUP 8'h20
`define PPC_OFS_P9_FALL_EN 8'h24
`define PPC_OFS_P9_RISE_EN 8'h28

`define PPC_P4_PULLUP_RST 8'h00
`define PPC_P4_PULLUP_MASK 8'h7f
`define PPC_P8_LEVEL_MASK 8'h03
`define PPC_P9_RST 16'h0000
`define PPC_P9_DIR_RST 16'hffff
`define PPC_P9_INT_LO 2
`define PPC_P9_INT_HI 3
`define PPC_P7_WIDTH_MAX 16
`define PPC_P8_WIDTH 2
`define PPC_P9_WIDTH 16

`endif

// ==== rtl/ppc_top.v ====
// Port pin control group: port 4 pull-ups, input ports 7 and 8, bidirectional port 9
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
`include "ppc_map.vh"

// Operation
// - Port 4 pull-up select is 8 bits, resets to zero, byte or bit access.
// - Bits 0..6 connect their pin pull-up when set; bit 7 reads zero.
// - Port 7 pins are inputs only, without direction control or output driver.
// - Port 7 width is a build parameter, 12 or 16 bits.
// - Port 7 level register is 16 bits, returns pin levels, read-only.
// - Port 7 upper and lower bytes readable separately as bytes or bits.
// - Port 7 pins double as analog converter inputs, one channel per pin.
// - Port 8 has exactly two pins.
// - Port 8 level register is 8 bits read-only; bits 0,1 pins, rest zero.
// - Port 8 pins double as the two analog output channels.
// - Port 9 has sixteen bidirectional pins.
// - Port 9 data register holds output data and reads back inputs per bit.
// - Port 9 direction register picks input or output per pin.
// - Port 9 mode control picks general port or alternate function per pin.
// - Port 9 open-drain select picks push-pull or N-channel open-drain per pin.
// - Port 9 function control picks one of two alternates in control mode.
// - Port 9 pull-up select connects each pin pull-up independently.
// - Falling and rising edge enables choose the valid interrupt edge for pins 2 and 3 only.
// - Port 9 pins carry address, interrupt, timer, UART and serial alternates.
module ppc_top #(
   parameter P7_WIDTH = 16
) (
   input wire CLK,
   input wire NRST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [`PPC_ADDR_W-1:0] WB_ADR_I,
   input wire [3:0] WB_SEL_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   output wire WB_ACK_O,
   output wire [6:0] P4_PULLUP_EN,
   input wire [P7_WIDTH-1:0] P7_IN,
   input wire [`PPC_P8_WIDTH-1:0] P8_IN,
   input wire ANALOG_OUT_ACTIVE,
   input wire [`PPC_P9_WIDTH-1:0] P9_IN,
   output wire [`PPC_P9_WIDTH-1:0] P9_OUT,
   output wire [`PPC_P9_WIDTH-1:0] P9_OE,
   output wire [`PPC_P9_WIDTH-1:0] P9_PULLUP_EN,
   input wire [`PPC_P9_WIDTH-1:0] ADDR_BUS_OUT,
   input wire ADDR_BUS_OE,
   input wire [`PPC_P9_WIDTH-1:0] PERIPH_OUT,
   input wire [`PPC_P9_WIDTH-1:0] PERIPH_OE,
   output wire [`PPC_P9_WIDTH-1:0] PERIPH_IN,
   output wire [1:0] EXT_INT_EDGE
);

   // Bit positions of the one-hot register select
   localparam SEL_P4_PULLUP = 0;
   localparam SEL_P7_LEVEL = 1;
   localparam SEL_P8_LEVEL = 2;
   localparam SEL_P9_DATA = 3;
   localparam SEL_P9_DIR = 4;
   localparam SEL_P9_MODE = 5;
   localparam SEL_P9_OPEN_DRAIN = 6;
   localparam SEL_P9_FUNC = 7;
   localparam SEL_P9_PULLUP = 8;
   localparam SEL_P9_FALL_EN = 9;
   localparam SEL_P9_RISE_EN = 10;

   reg ack_q;
   reg [7:0] p4_pullup_q;
   reg [15:0] p9_data_q;
   reg [15:0] p9_dir_q;
   reg [15:0] p9_mode_q;
   reg [15:0] p9_od_q;
   reg [15:0] p9_func_q;
   reg [15:0] p9_pullup_q;
   reg [15:0] p9_fall_q;
   reg [15:0] p9_rise_q;
   reg [15:0] p9_in_q;
   reg [1:0] ext_int_q;
   reg [31:0] rd_d;
   reg ack_d;
   reg [7:0] p4_pullup_d;
   reg [15:0] p9_data_d;
   reg [15:0] p9_dir_d;
   reg [15:0] p9_mode_d;
   reg [15:0] p9_od_d;
   reg [15:0] p9_func_d;
   reg [15:0] p9_pullup_d;
   reg [15:0] p9_fall_d;
   reg [15:0] p9_rise_d;
   reg [1:0] ext_int_d;
   reg [15:0] p7_level;
   wire req;
   wire wr;
   wire [10:0] hit;
   wire [15:0] p9_read;
   wire [15:0] pin_drive;
   wire [15:0] pin_value;
   wire [15:0] alt_sel;
   wire [1:0] int_pin;
   wire [1:0] int_prev;
   wire [1:0] int_en;

   // Merge written byte lanes into a 16-bit register
   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] sel;
      begin
         merge16 = old;
         if (sel[0]) begin
            merge16[7:0] = data[7:0];
         end
         if (sel[1]) begin
            merge16[15:8] = data[15:8];
         end
      end
   endfunction

   // One-hot decode of the register offset; an unmapped address sets no bit
   function [10:0] reg_select;
      input [`PPC_ADDR_W-1:0] adr;
      begin
         reg_select = 11'h000;
         if (adr == `PPC_OFS_P4_PULLUP) begin
            reg_select[SEL_P4_PULLUP] = 1'b1;
         end else if (adr == `PPC_OFS_P7_LEVEL) begin
            reg_select[SEL_P7_LEVEL] = 1'b1;
         end else if (adr == `PPC_OFS_P8_LEVEL) begin
            reg_select[SEL_P8_LEVEL] = 1'b1;
         end else if (adr == `PPC_OFS_P9_DATA) begin
            reg_select[SEL_P9_DATA] = 1'b1;
         end else if (adr == `PPC_OFS_P9_DIR) begin
            reg_select[SEL_P9_DIR] = 1'b1;
         end else if (adr == `PPC_OFS_P9_MODE) begin
            reg_select[SEL_P9_MODE] = 1'b1;
         end else if (adr == `PPC_OFS_P9_OPEN_DRAIN) begin
            reg_select[SEL_P9_OPEN_DRAIN] = 1'b1;
         end else if (adr == `PPC_OFS_P9_FUNC) begin
            reg_select[SEL_P9_FUNC] = 1'b1;
         end else if (adr == `PPC_OFS_P9_PULLUP) begin
            reg_select[SEL_P9_PULLUP] = 1'b1;
         end else if (adr == `PPC_OFS_P9_FALL_EN) begin
            reg_select[SEL_P9_FALL_EN] = 1'b1;
         end else if (adr == `PPC_OFS_P9_RISE_EN) begin
            reg_select[SEL_P9_RISE_EN] = 1'b1;
         end
      end
   endfunction

   assign req = WB_CYC_I & WB_STB_I & ~ack_q;
   assign wr = req & WB_WE_I;
   assign hit = reg_select(WB_ADR_I);
   assign WB_ACK_O = ack_q;

   // Port 7 sits in the low bits; absent bits of the small variant read zero
   always @* begin
      p7_level = 16'h0000;
      p7_level[P7_WIDTH-1:0] = P7_IN;
   end

   // Input-mode bits read the pin, output-mode bits read the latch
   assign p9_read = (p9_dir_q & P9_IN) | (~p9_dir_q & p9_data_q);

   always @* begin
      rd_d = 32'h00000000;
      if (hit[SEL_P4_PULLUP]) begin
         rd_d[7:0] = p4_pullup_q & `PPC_P4_PULLUP_MASK;
      end else if (hit[SEL_P7_LEVEL]) begin
         rd_d[15:0] = p7_level;
      end else if (hit[SEL_P8_LEVEL]) begin
         rd_d[7:0] = {6'h00, P8_IN} & `PPC_P8_LEVEL_MASK;
      end else if (hit[SEL_P9_DATA]) begin
         rd_d[15:0] = p9_read;
      end else if (hit[SEL_P9_DIR]) begin
         rd_d[15:0] = p9_dir_q;
      end else if (hit[SEL_P9_MODE]) begin
         rd_d[15:0] = p9_mode_q;
      end else if (hit[SEL_P9_OPEN_DRAIN]) begin
         rd_d[15:0] = p9_od_q;
      end else if (hit[SEL_P9_FUNC]) begin
         rd_d[15:0] = p9_func_q;
      end else if (hit[SEL_P9_PULLUP]) begin
         rd_d[15:0] = p9_pullup_q;
      end else if (hit[SEL_P9_FALL_EN]) begin
         rd_d[15:0] = p9_fall_q;
      end else if (hit[SEL_P9_RISE_EN]) begin
         rd_d[15:0] = p9_rise_q;
      end
   end

   // Acknowledge follows every accepted request by one cycle
   always @* begin
      ack_d = req;
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ack_q <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         ack_q <= ack_d;
         if (req) begin
            WB_DAT_O <= rd_d;
         end
      end
   end

   // Level registers of ports 7 and 8 have no write path at all
   always @* begin
      p4_pullup_d = p4_pullup_q;
      if (wr && hit[SEL_P4_PULLUP] && WB_SEL_I[0]) begin
         p4_pullup_d = WB_DAT_I[7:0] & `PPC_P4_PULLUP_MASK;
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p4_pullup_q <= `PPC_P4_PULLUP_RST;
      end else begin
         p4_pullup_q <= p4_pullup_d;
      end
   end

   always @* begin
      p9_data_d = p9_data_q;
      if (wr && hit[SEL_P9_DATA]) begin
         p9_data_d = merge16(p9_data_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_data_q <= `PPC_P9_RST;
      end else begin
         p9_data_q <= p9_data_d;
      end
   end

   always @* begin
      p9_dir_d = p9_dir_q;
      if (wr && hit[SEL_P9_DIR]) begin
         p9_dir_d = merge16(p9_dir_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_dir_q <= `PPC_P9_DIR_RST;
      end else begin
         p9_dir_q <= p9_dir_d;
      end
   end

   always @* begin
      p9_mode_d = p9_mode_q;
      if (wr && hit[SEL_P9_MODE]) begin
         p9_mode_d = merge16(p9_mode_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_mode_q <= `PPC_P9_RST;
      end else begin
         p9_mode_q <= p9_mode_d;
      end
   end

   always @* begin
      p9_od_d = p9_od_q;
      if (wr && hit[SEL_P9_OPEN_DRAIN]) begin
         p9_od_d = merge16(p9_od_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_od_q <= `PPC_P9_RST;
      end else begin
         p9_od_q <= p9_od_d;
      end
   end

   always @* begin
      p9_func_d = p9_func_q;
      if (wr && hit[SEL_P9_FUNC]) begin
         p9_func_d = merge16(p9_func_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_func_q <= `PPC_P9_RST;
      end else begin
         p9_func_q <= p9_func_d;
      end
   end

   always @* begin
      p9_pullup_d = p9_pullup_q;
      if (wr && hit[SEL_P9_PULLUP]) begin
         p9_pullup_d = merge16(p9_pullup_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_pullup_q <= `PPC_P9_RST;
      end else begin
         p9_pullup_q <= p9_pullup_d;
      end
   end

   always @* begin
      p9_fall_d = p9_fall_q;
      if (wr && hit[SEL_P9_FALL_EN]) begin
         p9_fall_d = merge16(p9_fall_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_fall_q <= `PPC_P9_RST;
      end else begin
         p9_fall_q <= p9_fall_d;
      end
   end

   always @* begin
      p9_rise_d = p9_rise_q;
      if (wr && hit[SEL_P9_RISE_EN]) begin
         p9_rise_d = merge16(p9_rise_q, WB_DAT_I, WB_SEL_I);
      end
   end

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_rise_q <= `PPC_P9_RST;
      end else begin
         p9_rise_q <= p9_rise_d;
      end
   end

   assign P4_PULLUP_EN = p4_pullup_q[6:0];

   // Port 7 and port 8 analog functions are wired at the pad; digital reads stay valid
   // ANALOG_OUT_ACTIVE only documents that port 8 serves the converter outputs

   // Control mode: function bit 0 selects the address bus, 1 the peripheral
   assign alt_sel = p9_mode_q;
   assign pin_value = (alt_sel & ~p9_func_q & ADDR_BUS_OUT)
                    | (alt_sel & p9_func_q & PERIPH_OUT)
                    | (~alt_sel & p9_data_q);
   assign pin_drive = (alt_sel & ~p9_func_q & {16{ADDR_BUS_OE}})
                    | (alt_sel & p9_func_q & PERIPH_OE)
                    | (~alt_sel & ~p9_dir_q);
   assign P9_OUT = pin_value & ~p9_od_q;
   // Open-drain bits only ever pull low
   assign P9_OE = pin_drive & (~p9_od_q | ~pin_value);
   assign P9_PULLUP_EN = p9_pullup_q;
   assign PERIPH_IN = P9_IN & alt_sel & p9_func_q;

   always @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         p9_in_q <= 16'h0000;
         ext_int_q <= 2'h0;
      end else begin
         p9_in_q <= P9_IN;
         ext_int_q <= ext_int_d;
      end
   end

   // Pulse for a valid edge on the two interrupt-capable pins
   always @* begin
      ext_int_d = (int_en & int_prev & ~int_pin & p9_fall_q[`PPC_P9_INT_HI:`PPC_P9_INT_LO])
                | (int_en & ~int_prev & int_pin & p9_rise_q[`PPC_P9_INT_HI:`PPC_P9_INT_LO]);
   end

   assign int_pin = P9_IN[`PPC_P9_INT_HI:`PPC_P9_INT_LO];
   assign int_prev = p9_in_q[`PPC_P9_INT_HI:`PPC_P9_INT_LO];
   assign int_en = alt_sel[`PPC_P9_INT_HI:`PPC_P9_INT_LO] & p9_func_q[`PPC_P9_INT_HI:`PPC_P9_INT_LO];
   assign EXT_INT_EDGE = ext_int_q;

endmodule // ppc_top

// ==== dv/ppc_pins.sv ====
// Board-side model of the port 9 pins
`timescale 1ns/100ps
module ppc_pins (
   input wire logic clk,
   input wire logic [15:0] p9_out,
   input wire logic [15:0] p9_oe,
   input wire logic [15:0] p9_pullup_en,
   input wire logic [15:0] ext_val,
   input wire logic [15:0] ext_en,
   output logic [15:0] p9_in
);
   logic [15:0] last_q = 16'h0000;
   wire [15:0] held = p9_oe | ext_en;
   // Only a driven level is remembered, so a floating pin stays put instead of toggling
   always @(posedge clk) last_q <= (held & p9_in) | (~held & last_q);
   // A floating pin without pull-up shows the inverse of the level last driven onto it
   assign p9_in = (p9_oe & p9_out) | (~p9_oe & ext_en & ext_val) | (~held & (p9_pullup_en | ~last_q));
endmodule // ppc_pins

// ==== dv/ppc_top_props.sv ====
// Bus and pin checks for the port pin control group
`timescale 1ns/100ps
`include "ppc_map.vh"
module ppc_top_props (
   input wire CLK,
   input wire NRST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_WE_I,
   input wire [`PPC_ADDR_W-1:0] WB_ADR_I,
   input wire WB_ACK_O,
   input wire [6:0] P4_PULLUP_EN,
   input wire [15:0] P9_IN,
   input wire [15:0] P9_OE,
   input wire [15:0] P9_PULLUP_EN,
   input wire [1:0] EXT_INT_EDGE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire req = WB_CYC_I && WB_STB_I;
   a_ack_follows_req: assert property (req && !WB_ACK_O |=> WB_ACK_O)
      else $error("ack missing");
   a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack too long");
   a_ack_no_req: assert property (!req |=> !WB_ACK_O)
      else $error("ack without request");
   a_p4_by_write: assert property ($changed(P4_PULLUP_EN) |-> WB_ACK_O && $past(WB_WE_I && WB_ADR_I == 8'h00))
      else $error("port 4 pull-ups moved without write");
   a_p9_pu_write: assert property ($changed(P9_PULLUP_EN) |-> WB_ACK_O && $past(WB_WE_I && WB_ADR_I == 8'h20))
      else $error("port 9 pull-ups moved without write");
   a_oe_reset: assert property ($rose(NRST) |-> P9_OE == 16'h0000)
      else $error("port 9 drives after reset");
   a_pullup_reset: assert property ($rose(NRST) |-> P4_PULLUP_EN == 7'h00 && P9_PULLUP_EN == 16'h0000)
      else $error("pull-ups on after reset");
   a_edge_needs_pin: assert property ($stable(P9_IN[3:2])[*4] |=> EXT_INT_EDGE == 2'b00)
      else $error("edge pulse without pin change");
   c_p4_write: cover property (WB_ACK_O && WB_WE_I && WB_ADR_I == 8'h00);
   c_p7_read: cover property (WB_ACK_O && !WB_WE_I && WB_ADR_I == 8'h04);
   c_edge: cover property (EXT_INT_EDGE[0]);
endmodule // ppc_top_props
bind ppc_top ppc_top_props u_props (.*);

// ==== dv/tb.sv ====
// Self-checking bench for the port pin control group
`timescale 1ns/100ps
`include "ppc_map.vh"
module tb;
   logic CLK = 0, NRST = 0, cyc = 0, stb = 0, we = 0, abe = 0, aoa = 0, w;
   logic [7:0] adr = 0, a8;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rd, exp_v;
   logic [15:0] p7 = 0, abo = 0, po = 0, poe = 0, ev = 0, en = 0, m[0:11];
   logic [1:0] p8 = 0, hit;
   logic [7:0] tab[0:8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2c};
   wire ack;
   wire [6:0] p4;
   wire [15:0] p9i, p9o, p9e, p9pu, pin_alt;
   wire [1:0] eie;
   wire [31:0] dato;
   integer seed = 32'h57e7, failures = 0, total_checks = 0, cycles = 0, i;
   initial forever #25 CLK = ~CLK;
   ppc_top dut (.CLK(CLK), .NRST(NRST), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
      .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dato), .WB_ACK_O(ack), .P4_PULLUP_EN(p4), .P7_IN(p7),
      .P8_IN(p8), .ANALOG_OUT_ACTIVE(aoa), .P9_IN(p9i), .P9_OUT(p9o), .P9_OE(p9e), .P9_PULLUP_EN(p9pu),
      .ADDR_BUS_OUT(abo), .ADDR_BUS_OE(abe), .PERIPH_OUT(po), .PERIPH_OE(poe), .PERIPH_IN(pin_alt),
      .EXT_INT_EDGE(eie));
   ppc_pins pins (.clk(CLK), .p9_out(p9o), .p9_oe(p9e), .p9_pullup_en(p9pu), .ext_val(ev), .ext_en(en),
      .p9_in(p9i));
   task wrap_up;
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up;
      end
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wb(input logic [7:0] a, input logic wr, input logic [3:0] s, input logic [31:0] d);
      @(posedge CLK);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, wr, a, s, d};
      do @(posedge CLK); while (ack !== 1'b1);
      rd = dato;
      {cyc, stb} <= 2'b00;
      if (wr && a != 8'h04 && a != 8'h08 && a != 8'h2c) begin
         if (s[0]) m[a >> 2][7:0] = d[7:0];
         if (s[1] && a != 8'h00) m[a >> 2][15:8] = d[15:8];
      end
   endtask
   initial begin
      for (i = 0; i < 12; i++) m[i] = 16'h0000;
      m[4] = 16'hffff;
      repeat (3) @(posedge CLK);
      NRST <= 1'b1;
      for (i = 0; i < 80; i++) begin
         {p7, p8, ev, abo, po, poe, abe, aoa} <= 84'({$random(seed), $random(seed), $random(seed)});
         en <= m[4];
         repeat (2) @(posedge CLK);
         a8 = i < 9 ? tab[i] : tab[$unsigned($random(seed)) % 9];
         w = i < 9 ? 1'b0 : 1'($random(seed));
         wb(a8, w, 4'($random(seed)), $random(seed));
         exp_v = a8 == 8'h00 ? m[0] & 16'h007f : a8 == 8'h04 ? p7 : a8 == 8'h08 ? p8 :
            a8 == 8'h0c ? (m[4] & ev) | (~m[4] & m[3]) : a8 == 8'h2c ? 0 : m[a8 >> 2];
         if (!w) chk("read", exp_v, rd);
         chk("pullup4", m[0][6:0], p4);
         chk("pullup9", m[8], p9pu);
         chk("oe", 16'(~m[4]), p9e);
         chk("out", m[3] & ~m[4], 16'(p9o & ~m[4]));
      end
      {poe, abe} <= 17'h00000;
      wb(8'h18, 1'b1, 4'h3, 32'h1);
      wb(8'h10, 1'b1, 4'h3, 32'hfffe);
      wb(8'h0c, 1'b1, 4'h3, 32'h1);
      chk("od release", 0, p9e[0]);
      wb(8'h0c, 1'b1, 4'h3, 32'h0);
      chk("od pull", 2'b01, {p9o[0], p9e[0]});
      {en, ev} <= 32'hffff0000;
      wb(8'h10, 1'b1, 4'h3, 32'hffff);
      wb(8'h14, 1'b1, 4'h3, 32'hc);
      wb(8'h1c, 1'b1, 4'h3, 32'hc);
      wb(8'h24, 1'b1, 4'h3, 32'h8);
      wb(8'h28, 1'b1, 4'h3, 32'hc);
      chk("alt in", 16'h0000, pin_alt);
      for (i = 5; i < 8; i++) begin
         wb(8'(i * 4), 1'b0, 4'h3, 32'h0);
         chk("ctl read", m[i], rd);
      end
      for (i = 0; i < 4; i++) begin
         ev[2 + i / 2] <= (i % 2 == 0);
         hit = 0;
         repeat (5) @(posedge CLK) hit = hit | eie;
         chk("edge", i == 0 ? 2'b01 : i == 1 ? 2'b00 : 2'b10, hit);
         chk("alt in", ev & 16'h000c, pin_alt);
      end
      wrap_up;
   end
endmodule // tb
